// File: rtl/rmpu_pkg.sv
// Purpose: Shared constants and types for the region protection unit
// Assumes: Register window at the region select address, 32-bit data
// Notes: Register layout follows the usual protection unit packing
package rmpu_pkg;

    localparam int NUM_REGIONS = 8;
    localparam logic [31:0] REG_SELECT_ADDR = 32'he000ed98;
    localparam logic [31:0] OFS_BASE = 32'h0000_0004;
    localparam logic [31:0] OFS_ATTR = 32'h0000_0008;
    localparam logic [31:0] OFS_ALIAS_STEP = 32'h0000_0008;
    localparam int NUM_ALIAS = 4;
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
    // Field positions
    localparam int BASE_VALID_BIT = 4;
    localparam int ATTR_ENABLE_BIT = 0;
    localparam int ATTR_SIZE_LSB = 1;
    localparam int ATTR_SRD_LSB = 8;
    localparam int ATTR_B_BIT = 16;
    localparam int ATTR_C_BIT = 17;
    localparam int ATTR_S_BIT = 18;
    localparam int ATTR_TEX_LSB = 19;
    localparam int ATTR_AP_LSB = 24;
    localparam int ATTR_XN_BIT = 28;
    localparam logic [4:0] SIZE_MIN_SUBREGION = 5'h07;
    localparam logic [4:0] SIZE_MIN = 5'h04;

    typedef enum logic [2:0] {
        MEM_STRONG = 3'h0,
        MEM_DEVICE = 3'h1,
        MEM_NORMAL = 3'h3,
        MEM_RESERVED = 3'h2
    } mem_type_t;

    typedef enum logic [1:0] {
        POL_NONCACHE = 2'h0,
        POL_WB_ALLOC = 2'h1,
        POL_WT_NOALLOC = 2'h2,
        POL_WB_NOALLOC = 2'h3
    } cache_pol_t;

    typedef struct packed {
        logic [31:0] addr;
        logic privileged;
        logic write;
        logic fetch;
    } access_t;

    typedef struct packed {
        mem_type_t mem_type;
        logic shareable;
        cache_pol_t outer_pol;
        cache_pol_t inner_pol;
    } mem_attr_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] byte_en;
        logic write;
        logic read;
    } reg_req_t;

endpackage : rmpu_pkg

// File: rtl/rmpu_attr_decode.sv
// Purpose: Decode type extension, shareable, cacheable, bufferable bits
// Assumes: Purely combinational
// Notes: Outputs are informational; no caching exists here
`timescale 1ns/1ps
module rmpu_attr_decode
    import rmpu_pkg::*;
(
    input wire logic [2:0] tex_i,
    input wire logic s_i,
    input wire logic c_i,
    input wire logic b_i,
    output rmpu_pkg::mem_attr_t attr_o
);
    wire [1:0] cb = {c_i, b_i};
    wire is_tex0 = (tex_i == 3'h0);
    wire is_tex1 = (tex_i == 3'h1);
    wire is_tex2 = (tex_i == 3'h2);

    always_comb
    begin
        attr_o = '{MEM_RESERVED, 1'b0, POL_NONCACHE, POL_NONCACHE};
        if (tex_i[2])
        begin
            attr_o = '{MEM_NORMAL, s_i, cache_pol_t'(tex_i[1:0]), cache_pol_t'(cb)}; // R20 R24
        end
        else if (is_tex0)
        begin
            if (cb == 2'h0)
                attr_o = '{MEM_STRONG, 1'b1, POL_NONCACHE, POL_NONCACHE}; // R16
            else if (cb == 2'h1)
                attr_o = '{MEM_DEVICE, 1'b1, POL_NONCACHE, POL_NONCACHE}; // R16 R19
            else
                attr_o = '{MEM_NORMAL, s_i, POL_WT_NOALLOC, POL_WT_NOALLOC}; // R16 R17
        end
        else if (is_tex1)
        begin
            if (cb == 2'h0)
                attr_o = '{MEM_NORMAL, s_i, POL_NONCACHE, POL_NONCACHE}; // R18
            else if (cb == 2'h3)
                attr_o = '{MEM_NORMAL, s_i, POL_WB_ALLOC, POL_WB_ALLOC}; // R18
        end
        else if (is_tex2 && cb == 2'h0)
        begin
            attr_o = '{MEM_DEVICE, 1'b0, POL_NONCACHE, POL_NONCACHE}; // R19
        end
    end
endmodule : rmpu_attr_decode

// File: rtl/rmpu_region_match.sv
// Purpose: Address match of one region, with subregion disables
// Assumes: Base aligned to size by software
// Notes: Size field n gives 2^(n+1) bytes
`timescale 1ns/1ps
module rmpu_region_match
    import rmpu_pkg::*;
(
    input wire logic [31:0] addr_i,
    input wire logic [31:0] base_i,
    input wire logic [31:0] attr_i,
    output logic hit_o
);
    wire [4:0] size = attr_i[ATTR_SIZE_LSB +: 5];
    wire [7:0] subregion_disable_mask = attr_i[ATTR_SRD_LSB +: 8];
    wire [5:0] log2 = {1'b0, size} + 6'h01;
    wire [31:0] mask = (log2 >= 6'h20) ? 32'h0 : (32'hffffffff << log2[4:0]);
    wire in_range = ((addr_i & mask) == (base_i & mask));
    wire [4:0] sub_sh = log2[4:0] - 5'h03;
    wire [2:0] sub_idx = (log2 >= 6'h20) ? addr_i[31:29] : 3'(addr_i >> sub_sh);
    wire has_sub = (size >= SIZE_MIN_SUBREGION);
    wire sub_off = has_sub && subregion_disable_mask[sub_idx]; // R12 R13

    assign hit_o = attr_i[ATTR_ENABLE_BIT] && (size >= SIZE_MIN) && in_range && !sub_off; // R9
endmodule : rmpu_region_match

// File: rtl/rmpu_top.sv
// Purpose: Region memory protection unit with register window
// Assumes: Access and register requests synchronous to CLK_I
// Notes: Check is combinational; registers update on clock edge
// Behaviour
// R1: Eight numbered regions plus background region
// R2: Overlap resolved by highest region number
// R3: Background region privileged only, default attributes
// R4: Fetches and data share one table
// R5: Prohibited access raises memory management fault
// R6: Software uses aligned word accesses, attr also smaller
// R7: Unaligned register accesses not supported
// R8: Select at fixed address, base +4, attr +8
// R9: Enable bit zero enables selected region
// R10: Alias pairs allow programming four regions
// R11: Base write with valid selects region
// R12: Large regions split into eight subregions
// R13: Disabled subregion falls through or faults
// R14: Software zeroes subregion mask for small regions
// R15: Missing permission raises permission fault
// R16: Type zero decodes strong, device, normal
// R17: Type zero cacheable means write-through
// R18: Type one: noncache, write-back, reserved
// R19: Shareable ignored; type two device
// R20: High type values mark cached normal
// R21: Attributes have no effect on access
// R22: Software disables region before reprogramming
// R23: Software disables unused regions
// R24: Two-bit cache policy code decoding
// R25: Three-bit permission code decoding
// R26: Fault presented in the access cycle
`timescale 1ns/1ps
module rmpu_top
    import rmpu_pkg::*;
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic MPU_ENABLE_I,
    input wire logic ACC_VALID_I,
    input wire rmpu_pkg::access_t ACC_I,
    output logic ACC_FAULT_O,
    output logic ACC_BG_O,
    output logic [3:0] ACC_REGION_O,
    output rmpu_pkg::mem_attr_t ACC_ATTR_O,
    input wire rmpu_pkg::reg_req_t REG_I,
    output logic REG_HIT_O,
    output logic [31:0] REG_RDATA_O
);
    logic [2:0] select_ff;
    logic [31:0] base_ff [NUM_REGIONS];
    logic [31:0] attr_ff [NUM_REGIONS];
    logic [31:0] rdata_ff;
    logic [NUM_REGIONS-1:0] hit;

    // Register decode
    wire [31:0] offs = REG_I.addr - REG_SELECT_ADDR;
    wire in_win = (REG_I.addr >= REG_SELECT_ADDR) && (offs < (OFS_ATTR + 32'h4 +
        OFS_ALIAS_STEP * (NUM_ALIAS - 1)));
    wire sel_hit = in_win && (offs[31:2] == 30'h0);
    wire base_hit = in_win && !sel_hit && (offs[2] == 1'b1); // R10
    wire attr_hit = in_win && !sel_hit && (offs[2] == 1'b0); // R10
    wire word_be = (REG_I.byte_en == 4'hf);
    wire aligned = (REG_I.addr[1:0] == 2'h0);
    // Byte lane must match address; halfwords on even halfword only
    wire [3:0] lane_be = 4'h1 << REG_I.addr[1:0];
    wire attr_be_ok = (REG_I.byte_en == lane_be) ||
        ((REG_I.byte_en == 4'h3) && (REG_I.addr[1:0] == 2'h0)) ||
        ((REG_I.byte_en == 4'hc) && (REG_I.addr[1:0] == 2'h2)) ||
        (word_be && aligned);
    wire acc_ok = attr_hit ? attr_be_ok : (aligned && word_be); // R6 R7
    wire wr = REG_I.write && in_win && acc_ok;
    wire base_valid = REG_I.wdata[BASE_VALID_BIT];
    wire [2:0] wr_region = (base_hit && base_valid) ? REG_I.wdata[2:0] : select_ff; // R11
    wire [31:0] be_mask = {{8{REG_I.byte_en[3]}}, {8{REG_I.byte_en[2]}},
        {8{REG_I.byte_en[1]}}, {8{REG_I.byte_en[0]}}};
    wire [31:0] nxt_attr = (attr_ff[select_ff] & ~be_mask) | (REG_I.wdata & be_mask); // R8
    wire [31:0] base_rd = {base_ff[select_ff][31:5], 2'h0, select_ff};
    wire [31:0] rd_val = sel_hit ? {29'h0, select_ff} :
        (base_hit ? base_rd : attr_ff[select_ff]);

    assign REG_HIT_O = in_win && acc_ok;

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            select_ff <= SELECT_RESET[2:0];
        end
        else if (wr && sel_hit)
        begin
            select_ff <= REG_I.wdata[2:0]; // R8
        end
        else if (wr && base_hit && base_valid)
        begin
            select_ff <= REG_I.wdata[2:0]; // R11
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g++)
        begin : g_region
            always_ff @(posedge CLK_I or negedge ARST_N_I)
            begin
                if (!ARST_N_I)
                begin
                    base_ff[g] <= BASE_RESET;
                    attr_ff[g] <= ATTR_RESET;
                end
                else if (wr && base_hit && wr_region == 3'(g))
                begin
                    base_ff[g] <= {REG_I.wdata[31:5], 5'h0}; // R10 R11
                end
                else if (wr && attr_hit && select_ff == 3'(g))
                begin
                    attr_ff[g] <= nxt_attr; // R8 R9
                end
            end

            rmpu_region_match u_match (
                .addr_i(ACC_I.addr),
                .base_i(base_ff[g]),
                .attr_i(attr_ff[g]),
                .hit_o(hit[g])
            ); // R1 R4
        end
    endgenerate

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            rdata_ff <= 32'h0;
        else if (REG_I.read && in_win && acc_ok)
            rdata_ff <= rd_val;
    end
    assign REG_RDATA_O = rdata_ff;

    // Priority select, highest number wins
    logic [3:0] win;
    always_comb
    begin
        win = 4'h8;
        for (int i = 0; i < NUM_REGIONS; i++)
        begin
            if (hit[i])
                win = 4'(i); // R2
        end
    end
    wire any_hit = !win[3];
    wire [31:0] wattr = attr_ff[win[2:0]];
    wire [2:0] ap = wattr[ATTR_AP_LSB +: 3];
    wire xn = wattr[ATTR_XN_BIT];

    // Permission decode
    logic perm_ok;
    always_comb
    begin
        perm_ok = 1'b0;
        case (ap) // R25
            3'h0: perm_ok = 1'b0;
            3'h1: perm_ok = ACC_I.privileged;
            3'h2: perm_ok = ACC_I.privileged || !ACC_I.write;
            3'h3: perm_ok = 1'b1;
            3'h5: perm_ok = ACC_I.privileged && !ACC_I.write;
            3'h6, 3'h7: perm_ok = !ACC_I.write;
            default: perm_ok = 1'b0;
        endcase
        if (ACC_I.fetch && xn)
            perm_ok = 1'b0; // R15
    end

    mem_attr_t region_attr;
    rmpu_attr_decode u_attr (
        .tex_i(wattr[ATTR_TEX_LSB +: 3]),
        .s_i(wattr[ATTR_S_BIT]),
        .c_i(wattr[ATTR_C_BIT]),
        .b_i(wattr[ATTR_B_BIT]),
        .attr_o(region_attr)
    );

    wire bg_use = MPU_ENABLE_I && !any_hit;
    wire fault_raw = MPU_ENABLE_I && (any_hit ? !perm_ok : !ACC_I.privileged); // R3 R13 R15
    assign ACC_FAULT_O = ACC_VALID_I && fault_raw; // R5 R26
    assign ACC_BG_O = ACC_VALID_I && bg_use; // R3
    assign ACC_REGION_O = (MPU_ENABLE_I && ACC_VALID_I) ? win : 4'h8;
    // Attributes exported only; no effect on access
    assign ACC_ATTR_O = (MPU_ENABLE_I && any_hit) ? region_attr :
        '{MEM_NORMAL, 1'b0, POL_NONCACHE, POL_NONCACHE}; // R21

    // Checks on the access path and the register window
    property p_prio;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (MPU_ENABLE_I && ACC_VALID_I && hit[7]) |-> ACC_REGION_O == 4'h7;
    endproperty
    a_prio: assert property (p_prio) // R2
        else $error("Highest region not selected");

    property p_bg_refuse;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (MPU_ENABLE_I && ACC_VALID_I && hit == 8'h0 && !ACC_I.privileged) |-> ACC_FAULT_O;
    endproperty
    a_bg_refuse: assert property (p_bg_refuse) // R3
        else $error("Unprivileged background access not refused");

    property p_bg_flag;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (MPU_ENABLE_I && ACC_VALID_I && hit == 8'h0) |-> ACC_BG_O && ACC_REGION_O == 4'h8;
    endproperty
    a_bg_flag: assert property (p_bg_flag) // R3
        else $error("Background region not flagged");

    property p_sel;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (wr && sel_hit) |=> select_ff == $past(REG_I.wdata[2:0]);
    endproperty
    a_sel: assert property (p_sel) // R8
        else $error("Region select not updated");

    property p_rdata;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (REG_I.read && REG_HIT_O && sel_hit) |=> REG_RDATA_O == {29'h0, $past(select_ff)};
    endproperty
    a_rdata: assert property (p_rdata) // R8
        else $error("Select read data wrong");

    property p_perm;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (MPU_ENABLE_I && ACC_VALID_I && any_hit && ap == 3'h0) |-> ACC_FAULT_O;
    endproperty
    a_perm: assert property (p_perm) // R25
        else $error("No-access region did not fault");

    property p_xn;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (MPU_ENABLE_I && ACC_VALID_I && any_hit && xn && ACC_I.fetch) |-> ACC_FAULT_O;
    endproperty
    a_xn: assert property (p_xn) // R15
        else $error("Execute-never fetch did not fault");

    property p_valid;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (wr && base_hit && base_valid) |=> select_ff == $past(REG_I.wdata[2:0]);
    endproperty
    a_valid: assert property (p_valid) // R11
        else $error("Valid base write did not select region");

    property p_base_wr;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (wr && base_hit) |=> base_ff[$past(wr_region)] == {$past(REG_I.wdata[31:5]), 5'h0};
    endproperty
    a_base_wr: assert property (p_base_wr) // R10
        else $error("Base write did not land");

    property p_disabled;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        !attr_ff[7][ATTR_ENABLE_BIT] |-> !hit[7];
    endproperty
    a_disabled: assert property (p_disabled) // R9
        else $error("Disabled region matched");

    property p_nofault;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        !ACC_VALID_I |-> !ACC_FAULT_O;
    endproperty
    a_nofault: assert property (p_nofault) // R26
        else $error("Fault without access");

    property p_off;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        !MPU_ENABLE_I |-> !ACC_FAULT_O && ACC_REGION_O == 4'h8;
    endproperty
    a_off: assert property (p_off) // R5
        else $error("Fault while protection off");

    property p_unal;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (!aligned && word_be) |-> !REG_HIT_O;
    endproperty
    a_unal: assert property (p_unal) // R7
        else $error("Unaligned access accepted");

    property p_unal_half;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        (REG_I.addr[0] && (REG_I.byte_en == 4'h3 || REG_I.byte_en == 4'hc)) |-> !REG_HIT_O;
    endproperty
    a_unal_half: assert property (p_unal_half) // R7
        else $error("Unaligned halfword accepted");

    c_fault: cover property (@(posedge CLK_I)
        ACC_FAULT_O);
    c_bg: cover property (@(posedge CLK_I)
        ACC_BG_O && !ACC_FAULT_O);
    c_alias: cover property (@(posedge CLK_I)
        wr && base_hit && offs != OFS_BASE);
    c_overlap: cover property (@(posedge CLK_I)
        ACC_VALID_I && hit[0] && hit[1]);
    c_half: cover property (@(posedge CLK_I)
        wr && attr_hit && REG_I.byte_en == 4'hc);
endmodule : rmpu_top

// File: tb/rmpu_core_model.sv
// Purpose: Core model issuing one access at a time
// Assumes: Access driven at falling edge, taken at rising edge
// Notes: Idle address shows inverse of last one
`timescale 1ns/1ps
module rmpu_core_model
    import rmpu_pkg::*;
(
    input wire logic clk_i,
    input wire logic fault_i,
    input wire logic [3:0] region_i,
    input wire rmpu_pkg::mem_attr_t attr_i,
    input wire logic bg_i,
    output logic valid_o,
    output rmpu_pkg::access_t acc_o
);
    initial valid_o = 1'h0;
    initial acc_o = '0;

    // Same task for fetch and data accesses
    task automatic access(input logic [31:0] a, input logic [2:0] pwf, output logic flt,
        output logic [3:0] rg, output mem_attr_t at, output logic bg);
        @(negedge clk_i);
        valid_o = 1'h1;
        acc_o = {a, pwf};
        @(posedge clk_i);
        flt = fault_i;
        rg = region_i;
        at = attr_i;
        bg = bg_i;
        @(negedge clk_i);
        valid_o = 1'h0;
        acc_o = ~acc_o;
    endtask : access
endmodule : rmpu_core_model

// File: tb/test_rmpu_top.sv
// Purpose: Self-checking bench for the region protection unit
// Assumes: Inputs change at falling edge
// Notes: Region 3 serves the attribute and permission sweeps
`timescale 1ns/1ps
module test_rmpu_top;
    import rmpu_pkg::*;
    localparam logic [31:0] SEL = REG_SELECT_ADDR;
    localparam logic [31:0] BAS = REG_SELECT_ADDR + OFS_BASE;
    localparam logic [31:0] ATR = REG_SELECT_ADDR + OFS_ATTR;
    localparam logic [31:0] STP = OFS_ALIAS_STEP;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic mpu_en = 1'h0;
    logic acc_valid, fault, hit, flt, bg, bgs;
    access_t acc;
    logic [3:0] region, rg;
    mem_attr_t attr, at;
    reg_req_t req = '0;
    logic [31:0] rdata, rd;
    int error_cnt = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    rmpu_top u_rmpu_top (.CLK_I(clk), .ARST_N_I(arst_n), .MPU_ENABLE_I(mpu_en),
        .ACC_VALID_I(acc_valid), .ACC_I(acc), .ACC_FAULT_O(fault), .ACC_BG_O(bg),
        .ACC_REGION_O(region), .ACC_ATTR_O(attr), .REG_I(req), .REG_HIT_O(hit),
        .REG_RDATA_O(rdata));
    rmpu_core_model u_rmpu_core_model (.clk_i(clk), .fault_i(fault), .region_i(region),
        .attr_i(attr), .bg_i(bg), .valid_o(acc_valid), .acc_o(acc));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic [31:0] a, d, input logic [3:0] be, input logic w, eh,
        output logic [31:0] q);
        @(negedge clk);
        req = '{addr: a, wdata: d, byte_en: be, write: w, read: ~w};
        @(posedge clk);
        chk(hit, eh);
        @(negedge clk);
        req = '{addr: ~a, wdata: ~d, byte_en: be, write: 1'h0, read: 1'h0};
        q = rdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, d);
        bus(a, d, 4'hf, 1'h1, 1'h1, rd);
    endtask : wr
    task automatic rdc(input logic [31:0] a, exp);
        bus(a, 32'h0, 4'hf, 1'h0, 1'h1, rd);
        chk(rd, exp);
    endtask : rdc
    task automatic ac(input logic [31:0] a, input logic [2:0] pwf, input logic ef,
        input logic [3:0] er);
        u_rmpu_core_model.access(a, pwf, flt, rg, at, bgs);
        chk(flt, ef);
        chk(rg, er);
        chk(bgs, (er == 4'h8) && mpu_en);
    endtask : ac
    function automatic logic [31:0] mk(input logic xn, input logic [2:0] ap, type_extension_field, scb,
        input logic [7:0] subregion_disable_mask, input logic [4:0] sz);
        return {3'h0, xn, 1'h0, ap, 2'h0, type_extension_field, scb, subregion_disable_mask, 2'h0, sz, 1'h1};
    endfunction : mk
    // Disable, set upper half, re-enable; size 256 bytes
    task automatic prog3(input logic [31:0] w);
        bus(ATR, 32'h0000_000e, 4'h1, 1'h1, 1'h1, rd);
        bus(ATR + 2, w, 4'hc, 1'h1, 1'h1, rd);
        bus(ATR, 32'h0000_000f, 4'h1, 1'h1, 1'h1, rd);
    endtask : prog3
    task automatic atc(input logic [2:0] type_extension_field, scb, input logic full, input mem_type_t t,
        input logic s, input logic [1:0] o, i);
        prog3(mk(1'h0, 3'h3, type_extension_field, scb, 8'h00, 5'h07));
        ac(32'h4000_0000, 3'h6, 1'h0, 4'h3);
        if (full)
            chk(at, {t, s, o, i});
        else
            chk(at.mem_type, t);
    endtask : atc
    task automatic pc(input logic [2:0] ap, input logic [3:0] ef);
        prog3(mk(1'h0, ap, 3'h0, 3'h2, 8'h00, 5'h07));
        for (int j = 0; j < 4; j++)
            ac(32'h4000_0000, {j < 2, j[0], 1'h0}, ef[3-j], 4'h3);
    endtask : pc
    task automatic stop_test();
        $display("Counts: %0d checks, %0d errors", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    initial
    begin
        #50000;
        error_cnt++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(negedge clk);
        arst_n = 1'h1;
        mpu_en = 1'h1;
        // All regions start disabled
        rdc(SEL, SELECT_RESET);
        rdc(BAS, BASE_RESET);
        rdc(ATR, ATTR_RESET);
        $display("Test reset done");
        ac(32'h1000_0000, 3'h4, 1'h0, 4'h8);
        ac(32'h1000_0000, 3'h1, 1'h1, 4'h8);
        $display("Test background done");
        wr(SEL, 32'h0);
        wr(BAS, 32'h2000_0000);
        wr(ATR, mk(1'h0, 3'h3, 3'h0, 3'h2, 8'h00, 5'h09));
        ac(32'h2000_0300, 3'h2, 1'h0, 4'h0);
        ac(32'h2000_0400, 3'h0, 1'h1, 4'h8);
        wr(BAS, 32'h2000_0011);
        rdc(SEL, 32'h1);
        wr(ATR, mk(1'h0, 3'h6, 3'h0, 3'h2, 8'h01, 5'h07));
        ac(32'h2000_0040, 3'h6, 1'h1, 4'h1);
        ac(32'h2000_0010, 3'h0, 1'h0, 4'h0);
        $display("Test overlap done");
        wr(BAS + STP, 32'h3000_0012);
        wr(ATR + STP, mk(1'h0, 3'h3, 3'h0, 3'h2, 8'h80, 5'h07));
        ac(32'h3000_00c0, 3'h0, 1'h0, 4'h2);
        ac(32'h3000_00e0, 3'h0, 1'h1, 4'h8);
        bus(ATR, 32'h0000_000e, 4'h1, 1'h1, 1'h1, rd);
        ac(32'h3000_00c0, 3'h0, 1'h1, 4'h8);
        bus(ATR, 32'h0000_000f, 4'h1, 1'h1, 1'h1, rd);
        ac(32'h3000_00c0, 3'h0, 1'h0, 4'h2);
        $display("Test alias and enable done");
        wr(BAS + 3 * STP, 32'h4000_0013);
        wr(ATR + 3 * STP, mk(1'h1, 3'h1, 3'h0, 3'h2, 8'h00, 5'h07));
        ac(32'h4000_0000, 3'h0, 1'h1, 4'h3);
        ac(32'h4000_0000, 3'h5, 1'h1, 4'h3);
        ac(32'h4000_0000, 3'h6, 1'h0, 4'h3);
        bus(SEL, 32'h5, 4'h3, 1'h1, 1'h0, rd);
        bus(ATR + 1, 32'h0, 4'hf, 1'h1, 1'h0, rd);
        bus(32'he000edbc, 32'h0, 4'hf, 1'h1, 1'h0, rd);
        rdc(SEL, 32'h3);
        @(negedge clk);
        mpu_en = 1'h0;
        ac(32'h3000_00e0, 3'h0, 1'h0, 4'h8);
        mpu_en = 1'h1;
        $display("Test refusal done");
        atc(3'h0, 3'h4, 1'h0, MEM_STRONG, 1'h0, 2'h0, 2'h0);
        atc(3'h0, 3'h1, 1'h0, MEM_DEVICE, 1'h0, 2'h0, 2'h0);
        atc(3'h0, 3'h2, 1'h1, MEM_NORMAL, 1'h0, 2'h2, 2'h2);
        atc(3'h0, 3'h7, 1'h1, MEM_NORMAL, 1'h1, 2'h2, 2'h2);
        atc(3'h1, 3'h0, 1'h1, MEM_NORMAL, 1'h0, 2'h0, 2'h0);
        atc(3'h1, 3'h7, 1'h1, MEM_NORMAL, 1'h1, 2'h1, 2'h1);
        atc(3'h1, 3'h1, 1'h0, MEM_RESERVED, 1'h0, 2'h0, 2'h0);
        atc(3'h1, 3'h2, 1'h0, MEM_RESERVED, 1'h0, 2'h0, 2'h0);
        atc(3'h2, 3'h0, 1'h0, MEM_DEVICE, 1'h0, 2'h0, 2'h0);
        atc(3'h2, 3'h1, 1'h0, MEM_RESERVED, 1'h0, 2'h0, 2'h0);
        atc(3'h2, 3'h2, 1'h0, MEM_RESERVED, 1'h0, 2'h0, 2'h0);
        atc(3'h5, 3'h2, 1'h1, MEM_NORMAL, 1'h0, 2'h1, 2'h2);
        atc(3'h7, 3'h4, 1'h1, MEM_NORMAL, 1'h1, 2'h3, 2'h0);
        atc(3'h6, 3'h3, 1'h1, MEM_NORMAL, 1'h0, 2'h2, 2'h3);
        $display("Test attributes done");
        pc(3'h0, 4'hf);
        pc(3'h1, 4'h3);
        pc(3'h2, 4'h1);
        pc(3'h3, 4'h0);
        pc(3'h5, 4'h7);
        pc(3'h6, 4'h5);
        pc(3'h7, 4'h5);
        $display("Test permissions done");
        stop_test();
    end
endmodule : test_rmpu_top
